// ---- lrb_map.svh ----
`ifndef LRB_MAP_SVH
`define LRB_MAP_SVH

// ==========================================
// Register offsets
`define LRB_A_OPMODE  7'h00
`define LRB_A_FRF_H   7'h01
`define LRB_A_FRF_M   7'h02
`define LRB_A_FRF_L   7'h03
`define LRB_A_PRE_H   7'h04
`define LRB_A_PRE_L   7'h05
`define LRB_A_MODEM   7'h06
`define LRB_A_TXCFG   7'h07
`define LRB_A_PAYLEN  7'h08
`define LRB_A_DWELL   7'h09
`define LRB_A_TXBASE  7'h0A
`define LRB_A_RXBASE  7'h0B
`define LRB_A_PTR     7'h0C
`define LRB_A_DATA    7'h0D
`define LRB_A_RXCNT   7'h0E
`define LRB_A_CHAN    7'h0F
`define LRB_A_FLAGS   7'h10
`define LRB_A_RXCR    7'h11

// ==========================================
// Field positions
`define LRB_F_HOP     7
`define LRB_F_HLESS   6
`define LRB_F_CRCON   5
`define LRB_FL_DONE   0
`define LRB_FL_HERR   1
`define LRB_FL_HVAL   2

// ==========================================
// Reset values and fixed constants
`define LRB_R_PRE     16'h000C
`define LRB_R_SF      4'h7
`define LRB_R_CR      3'h1
`define LRB_R_DWELL   8'h01
`define LRB_PRE_MIN   16'h000C
`define LRB_PRE_MAX   16'h8000
`define LRB_HDR_CR    3'h4
`define LRB_HDR_SYMS  16'h0003
`define LRB_CRC_POLY  16'h1021

// ==========================================
// Timing
`define LRB_CLK_HZ      10000000
`define LRB_BW_BASE_HZ  125000
`define LRB_CHIP_DIV    (`LRB_CLK_HZ / `LRB_BW_BASE_HZ)
`define LRB_HOP_LEAD_MS 1
`define LRB_SCK_HALF    4

`endif

// ---- lrb_pkg.sv ----
package lrb_pkg;

	typedef enum logic [2:0] {
		MODE_SLEEP = 3'h0,
		MODE_STBY  = 3'h1,
		MODE_TX    = 3'h3,
		MODE_RXC   = 3'h5,
		MODE_RXS   = 3'h6
	} lrb_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_TX_PRE  = 3'h1,
		ST_TX_HDR  = 3'h2,
		ST_TX_PAY  = 3'h3,
		ST_RX_WAIT = 3'h4,
		ST_RX_HDR  = 3'h5,
		ST_RX_PAY  = 3'h6
	} lrb_pkt_e;

	typedef enum logic [1:0] {
		HS_IDLE  = 2'h0,
		HS_SHIFT = 2'h1,
		HS_GAP   = 2'h2
	} lrb_spi_e;

	typedef enum logic [1:0] {
		FK_USER  = 2'h0,
		FK_PTR   = 2'h1,
		FK_HOPRD = 2'h2,
		FK_HOPWR = 2'h3
	} lrb_frame_e;

endpackage : lrb_pkg

// ---- lrb_if.sv ----
`timescale 1ns/1ps
interface lrb_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic channel_change_irq;

	modport dev (input sclk, input cs_n, input mosi, output miso, output channel_change_irq);
	modport host (output sclk, output cs_n, output mosi, input miso, input channel_change_irq);
endinterface : lrb_if

// ---- lrb_dev.sv ----
`timescale 1ns/1ps
`include "lrb_map.svh"
// How it works
// - symbol rate is bandwidth over two-power-SF
// - packet is preamble, optional header, payload
// - preamble 12 default, 12..32768, receiver agnostic
// - explicit header default; carries length, rate, CRC
// - header at rate 4/8 with CRC; bad discarded
// - implicit mode omits header; ends configured alike
// - payload rate from header or registers; CRC
// - hop enable splits packet over channels
// - dwell whole symbols, then next channel
// - start channel 0; hop increments, raises interrupt
// - host reads channel, writes carrier frequency
// - receiver hops only after valid preamble
// - header CRC fail returns to channel 0; a hop in that same cycle sets the next channel instead
// - interrupt at least 1 ms before deadline
// - host writes configuration only sleep/standby; carrier frequency also in other modes
// - status readable in all modes but sleep
// - status cleared on receive entry from a non-receive mode
// - 256-byte two-port buffer, reached over SPI
// - transmit and receive base addresses programmable
// - data port access uses pointer, then increments
// - host loads pointer with base first
// - transmit payload length; receive count from header, or from payload length in implicit mode
// - buffer refused in sleep; contents kept
module lrb_dev #(
	parameter int BUF_DEPTH    = 256,
	parameter int HOP_LEAD_CYC = `LRB_HOP_LEAD_MS * (`LRB_CLK_HZ / 1000)
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Link
	lrb_if.dev              link,
	// Demodulator
	input  wire logic       dm_preamble,
	input  wire logic       dm_header,
	input  wire logic       dm_header_ok,
	input  wire logic [7:0] dm_len,
	input  wire logic [2:0] dm_cr,
	input  wire logic       dm_crc_on,
	input  wire logic       dm_byte_valid,
	input  wire logic [7:0] dm_byte,
	input  wire logic       dm_end,
	// Modulator and radio
	output logic            mod_valid,
	output logic [7:0]      mod_symbol,
	output logic [2:0]      mod_cr,
	output logic            mod_header,
	output logic [2:0]      rx_cr,
	output logic [23:0]     carrier_freq,
	output logic [2:0]      op_mode
);

	// ==========================================
	// State
	typedef struct packed {
		logic [2:0]        sy1;
		logic [2:0]        sy2;
		logic              sckp;
		logic [15:0]       sh;
		logic [4:0]        bits;
		logic [7:0]        rd;
		logic              miso;
		logic [2:0]        mode;
		logic [23:0]       frf;
		logic [15:0]       pre;
		logic [3:0]        sf;
		logic [1:0]        bw;
		logic              hop_enable;
		logic              headerless_select;
		logic              crc_on;
		logic [2:0]        cr;
		logic [7:0]        tx_payload_byte_count;
		logic [7:0]        dwell_symbol_count;
		logic [7:0]        tx_buffer_base;
		logic [7:0]        rx_buffer_base;
		logic [7:0]        buffer_access_pointer;
		logic [7:0]        received_byte_count;
		logic [2:0]        flags;
		logic [2:0]        rxcr;
		logic              rxcrc;
		logic [7:0]        current_channel_index;
		logic              irq;
		lrb_pkg::lrb_pkt_e st;
		logic [15:0]       idx;
		logic [19:0]       cyc;
		logic [7:0]        hsym;
		logic [23:0]       lead;
		logic [15:0]       crc;
		logic              mv;
		logic [7:0]        msym;
		logic [2:0]        mcr;
		logic              mhdr;
	} lrb_dev_s;

	lrb_dev_s r_reg;
	lrb_dev_s r_next;
	logic [7:0] mem [0:BUF_DEPTH-1];
	logic       we_a;
	logic [7:0] wa_a;
	logic [7:0] wd_a;
	logic       we_b;
	logic [7:0] wa_b;
	logic [7:0] wd_b;

	function automatic logic [15:0] lrb_crc(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] x;
		x = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++)
			x = x[15] ? ({x[14:0], 1'b0} ^ `LRB_CRC_POLY) : {x[14:0], 1'b0};
		return x;
	endfunction : lrb_crc

	// ==========================================
	// Next state
	always_comb
	begin
		logic        sck_r;
		logic        sck_f;
		logic        awake;
		logic        tick;
		logic        busy;
		logic [19:0] symc;
		logic [15:0] pre_eff;
		logic [6:0]  ra;
		logic [7:0]  rv;
		logic [6:0]  wa;
		logic [7:0]  wd;
		logic [7:0]  hb;
		r_next = r_reg;
		we_a = 1'b0;
		wa_a = r_reg.buffer_access_pointer;
		wd_a = 8'h00;
		we_b = 1'b0;
		wa_b = 8'h00;
		wd_b = 8'h00;
		r_next.sy1 = {link.mosi, link.cs_n, link.sclk};
		r_next.sy2 = r_reg.sy1;
		r_next.sckp = r_reg.sy2[0];
		sck_r = r_reg.sy2[0] & ~r_reg.sckp;
		sck_f = ~r_reg.sy2[0] & r_reg.sckp;
		awake = r_reg.mode != lrb_pkg::MODE_SLEEP;
		symc = 20'(`LRB_CHIP_DIV >> r_reg.bw) << r_reg.sf;
		busy = r_reg.st != lrb_pkg::ST_IDLE && r_reg.st != lrb_pkg::ST_RX_WAIT;
		tick = busy && r_reg.cyc == symc - 20'h00001;
		r_next.cyc = (tick || !busy) ? 20'h00000 : r_reg.cyc + 20'h00001;
		pre_eff = r_reg.pre < `LRB_PRE_MIN ? `LRB_PRE_MIN : (r_reg.pre > `LRB_PRE_MAX ? `LRB_PRE_MAX : r_reg.pre);
		ra = {r_reg.sh[5:0], r_reg.sy2[2]};
		wa = r_reg.sh[13:7];
		wd = {r_reg.sh[6:0], r_reg.sy2[2]};
		hb = {3'h0, r_reg.crc_on, 1'b0, r_reg.cr};
		unique case (ra)
			`LRB_A_OPMODE:  rv = {5'h00, r_reg.mode};
			`LRB_A_FRF_H:   rv = r_reg.frf[23:16];
			`LRB_A_FRF_M:   rv = r_reg.frf[15:8];
			`LRB_A_FRF_L:   rv = r_reg.frf[7:0];
			`LRB_A_PRE_H:   rv = r_reg.pre[15:8];
			`LRB_A_PRE_L:   rv = r_reg.pre[7:0];
			`LRB_A_MODEM:   rv = {r_reg.sf, 2'h0, r_reg.bw};
			`LRB_A_TXCFG:   rv = {r_reg.hop_enable, r_reg.headerless_select, r_reg.crc_on, 2'h0, r_reg.cr};
			`LRB_A_PAYLEN:  rv = r_reg.tx_payload_byte_count;
			`LRB_A_DWELL:   rv = r_reg.dwell_symbol_count;
			`LRB_A_TXBASE:  rv = r_reg.tx_buffer_base;
			`LRB_A_RXBASE:  rv = r_reg.rx_buffer_base;
			`LRB_A_PTR:     rv = r_reg.buffer_access_pointer;
			`LRB_A_DATA:    rv = awake ? mem[r_reg.buffer_access_pointer] : 8'h00;
			`LRB_A_RXCNT:   rv = awake ? r_reg.received_byte_count : 8'h00;
			`LRB_A_CHAN:    rv = r_reg.current_channel_index;
			`LRB_A_FLAGS:   rv = awake ? {5'h00, r_reg.flags} : 8'h00;
			`LRB_A_RXCR:    rv = awake ? {4'h0, r_reg.rxcrc, r_reg.rxcr} : 8'h00;
			default:        rv = 8'h00;
		endcase

		// ==========================================
		// SPI read half
		if (r_reg.sy2[1])
			r_next.bits = 5'h00;
		else if (sck_r)
		begin
			r_next.sh = {r_reg.sh[14:0], r_reg.sy2[2]};
			r_next.bits = r_reg.bits + 5'h01;
			if (r_reg.bits == 5'h07 && !r_reg.sh[6])
			begin
				r_next.rd = rv;
				r_next.miso = rv[7];
				if (ra == `LRB_A_DATA && awake)
					r_next.buffer_access_pointer = r_reg.buffer_access_pointer + 8'h01;
				if (ra == `LRB_A_CHAN)
					r_next.irq = 1'b0;
			end
		end
		else if (sck_f && r_reg.bits >= 5'h09)
		begin
			r_next.rd = {r_reg.rd[6:0], 1'b0};
			r_next.miso = r_reg.rd[6];
		end

		// ==========================================
		// Packet engine
		r_next.mv = 1'b0;
		unique case (r_reg.st)
			lrb_pkg::ST_IDLE: ;
			lrb_pkg::ST_TX_PRE:
				if (tick)
				begin
					r_next.mv = 1'b1;
					r_next.msym = 8'h00;
					r_next.mhdr = 1'b0;
					r_next.idx = r_reg.idx + 16'h0001;
					if (r_reg.idx + 16'h0001 >= pre_eff)
					begin
						r_next.idx = 16'h0000;
						r_next.crc = 16'h0000;
						r_next.st = r_reg.headerless_select ? lrb_pkg::ST_TX_PAY : lrb_pkg::ST_TX_HDR;
					end
				end
			lrb_pkg::ST_TX_HDR:
				if (tick)
				begin
					r_next.mv = 1'b1;
					r_next.mhdr = 1'b1;
					r_next.mcr = `LRB_HDR_CR;
					r_next.msym = r_reg.idx == 16'h0000 ? r_reg.tx_payload_byte_count :
						(r_reg.idx == 16'h0001 ? hb : r_reg.tx_payload_byte_count ^ hb);
					r_next.idx = r_reg.idx + 16'h0001;
					if (r_reg.idx + 16'h0001 >= `LRB_HDR_SYMS)
					begin
						r_next.idx = 16'h0000;
						r_next.st = lrb_pkg::ST_TX_PAY;
					end
				end
			lrb_pkg::ST_TX_PAY:
				if (tick)
				begin
					r_next.mhdr = 1'b0;
					r_next.mcr = r_reg.cr;
					r_next.idx = r_reg.idx + 16'h0001;
					if (r_reg.idx < {8'h00, r_reg.tx_payload_byte_count})
					begin
						r_next.mv = 1'b1;
						r_next.msym = mem[r_reg.tx_buffer_base + r_reg.idx[7:0]];
						r_next.crc = lrb_crc(r_reg.crc, mem[r_reg.tx_buffer_base + r_reg.idx[7:0]]);
					end
					else if (r_reg.crc_on && r_reg.idx < {8'h00, r_reg.tx_payload_byte_count} + 16'h0002)
					begin
						r_next.mv = 1'b1;
						r_next.msym = r_reg.idx == {8'h00, r_reg.tx_payload_byte_count} ? r_reg.crc[15:8] : r_reg.crc[7:0];
					end
					else
					begin
						r_next.st = lrb_pkg::ST_IDLE;
						r_next.mode = lrb_pkg::MODE_STBY;
					end
				end
			lrb_pkg::ST_RX_WAIT:
				if (dm_preamble)
				begin
					r_next.idx = 16'h0000;
					r_next.lead = 24'h000000;
					r_next.hsym = 8'h00;
					r_next.st = r_reg.headerless_select ? lrb_pkg::ST_RX_PAY : lrb_pkg::ST_RX_HDR;
					if (r_reg.headerless_select)
					begin
						r_next.received_byte_count = r_reg.tx_payload_byte_count;
						r_next.rxcr = r_reg.cr;
						r_next.rxcrc = r_reg.crc_on;
					end
				end
			lrb_pkg::ST_RX_HDR:
				if (dm_header)
				begin
					if (dm_header_ok)
					begin
						r_next.flags[`LRB_FL_HVAL] = 1'b1;
						r_next.received_byte_count = dm_len;
						r_next.rxcr = dm_cr;
						r_next.rxcrc = dm_crc_on;
						r_next.st = lrb_pkg::ST_RX_PAY;
					end
					else
					begin
						r_next.flags[`LRB_FL_HERR] = 1'b1;
						r_next.current_channel_index = 8'h00;
						r_next.st = lrb_pkg::ST_RX_WAIT;
					end
				end
			lrb_pkg::ST_RX_PAY:
			begin
				if (dm_byte_valid && r_reg.idx < {8'h00, r_reg.received_byte_count})
				begin
					we_b = 1'b1;
					wa_b = r_reg.rx_buffer_base + r_reg.idx[7:0];
					wd_b = dm_byte;
					r_next.idx = r_reg.idx + 16'h0001;
				end
				if (dm_end)
				begin
					r_next.flags[`LRB_FL_DONE] = 1'b1;
					r_next.current_channel_index = 8'h00;
					r_next.st = r_reg.mode == lrb_pkg::MODE_RXS ? lrb_pkg::ST_IDLE : lrb_pkg::ST_RX_WAIT;
					if (r_reg.mode == lrb_pkg::MODE_RXS)
						r_next.mode = lrb_pkg::MODE_STBY;
				end
			end
			default: r_next.st = lrb_pkg::ST_IDLE;
		endcase

		// ==========================================
		// Hopping
		if (r_reg.hop_enable && busy)
		begin
			if (r_reg.lead < 24'(HOP_LEAD_CYC))
				r_next.lead = r_reg.lead + 24'h000001;
			if (tick)
			begin
				r_next.hsym = r_reg.hsym + 8'h01;
				if (r_reg.hsym + 8'h01 >= r_reg.dwell_symbol_count && r_reg.lead >= 24'(HOP_LEAD_CYC))
				begin
					r_next.hsym = 8'h00;
					r_next.lead = 24'h000000;
					r_next.current_channel_index = r_reg.current_channel_index + 8'h01;
					r_next.irq = 1'b1;
				end
			end
		end

		// ==========================================
		// SPI write half
		if (!r_reg.sy2[1] && sck_r && r_reg.bits == 5'h0F && r_reg.sh[14])
		begin
			unique case (wa)
				`LRB_A_OPMODE:
				begin
					r_next.mode = wd[2:0];
					r_next.st = lrb_pkg::ST_IDLE;
					r_next.idx = 16'h0000;
					r_next.cyc = 20'h00000;
					r_next.lead = 24'h000000;
					r_next.hsym = 8'h00;
					if (wd[2:0] == lrb_pkg::MODE_TX)
					begin
						r_next.st = lrb_pkg::ST_TX_PRE;
						r_next.current_channel_index = 8'h00;
					end
					if (wd[2:0] == lrb_pkg::MODE_RXC || wd[2:0] == lrb_pkg::MODE_RXS)
					begin
						r_next.st = lrb_pkg::ST_RX_WAIT;
						r_next.current_channel_index = 8'h00;
						if (r_reg.mode != lrb_pkg::MODE_RXC && r_reg.mode != lrb_pkg::MODE_RXS)
						begin
							r_next.flags = 3'h0;
							r_next.received_byte_count = 8'h00;
							r_next.rxcr = 3'h0;
							r_next.rxcrc = 1'b0;
						end
					end
				end
				`LRB_A_FRF_H:   r_next.frf[23:16] = wd;
				`LRB_A_FRF_M:   r_next.frf[15:8] = wd;
				`LRB_A_FRF_L:   r_next.frf[7:0] = wd;
				`LRB_A_PRE_H:   r_next.pre[15:8] = wd;
				`LRB_A_PRE_L:   r_next.pre[7:0] = wd;
				`LRB_A_MODEM:
				begin
					r_next.sf = wd[7:4];
					r_next.bw = wd[1:0] > 2'h2 ? 2'h2 : wd[1:0];
				end
				`LRB_A_TXCFG:
				begin
					r_next.hop_enable = wd[`LRB_F_HOP];
					r_next.headerless_select = wd[`LRB_F_HLESS];
					r_next.crc_on = wd[`LRB_F_CRCON];
					r_next.cr = wd[2:0];
				end
				`LRB_A_PAYLEN:  r_next.tx_payload_byte_count = wd;
				`LRB_A_DWELL:   r_next.dwell_symbol_count = wd;
				`LRB_A_TXBASE:  r_next.tx_buffer_base = wd;
				`LRB_A_RXBASE:  r_next.rx_buffer_base = wd;
				`LRB_A_PTR:     r_next.buffer_access_pointer = wd;
				`LRB_A_DATA:
					if (awake)
					begin
						we_a = 1'b1;
						wd_a = wd;
						r_next.buffer_access_pointer = r_reg.buffer_access_pointer + 8'h01;
					end
				default: ;
			endcase
		end
	end

	// ==========================================
	// Registers and buffer
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg <= '0;
			r_reg.sy1 <= 3'h2;
			r_reg.sy2 <= 3'h2;
			r_reg.pre <= `LRB_R_PRE;
			r_reg.sf <= `LRB_R_SF;
			r_reg.cr <= `LRB_R_CR;
			r_reg.dwell_symbol_count <= `LRB_R_DWELL;
			r_reg.st <= lrb_pkg::ST_IDLE;
		end
		else
			r_reg <= r_next;
	end

	always_ff @(posedge clock)
	begin
		if (we_a)
			mem[wa_a] <= wd_a;
		if (we_b)
			mem[wa_b] <= wd_b;
	end

	assign link.miso = r_reg.miso;
	assign link.channel_change_irq = r_reg.irq;
	assign mod_valid = r_reg.mv;
	assign mod_symbol = r_reg.msym;
	assign mod_cr = r_reg.mcr;
	assign mod_header = r_reg.mhdr;
	assign rx_cr = r_reg.rxcr;
	assign carrier_freq = r_reg.frf;
	assign op_mode = r_reg.mode;

endmodule : lrb_dev

// ---- lrb_host.sv ----
`timescale 1ns/1ps
`include "lrb_map.svh"
module lrb_host #(
	parameter int SCK_HALF = `LRB_SCK_HALF,
	parameter int NCH      = 16
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Link
	lrb_if.host              link,
	// Hop frequency table
	input  wire logic        tbl_we,
	input  wire logic [7:0]  tbl_idx,
	input  wire logic [23:0] tbl_freq,
	// Commands
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic        cmd_write,
	input  wire logic [6:0]  cmd_addr,
	input  wire logic [7:0]  cmd_wdata,
	input  wire logic        cmd_rx_dir,
	// Read answers
	output logic             rsp_valid,
	input  wire logic        rsp_ready,
	output logic [7:0]       rsp_data
);

	// ==========================================
	// State
	typedef struct packed {
		lrb_pkg::lrb_spi_e   st;
		lrb_pkg::lrb_frame_e kind;
		logic [7:0]          div;
		logic                ph;
		logic [4:0]          bitn;
		logic [15:0]         sh;
		logic [7:0]          rx;
		logic                cs_n;
		logic                sck;
		logic                mosi;
		logic [1:0]          ms;
		logic [2:0]          ir;
		logic [2:0]          hstep;
		logic [7:0]          chan;
		logic                ptr_ok;
		logic                ptr_dir;
		logic [2:0]          mode;
		logic [7:0]          txb;
		logic [7:0]          rxb;
		logic                have;
		logic                cw;
		logic [6:0]          ca;
		logic [7:0]          cd;
		logic                cdir;
		logic [1:0]          cnt;
		logic [7:0]          b0;
		logic [7:0]          b1;
		logic                rdy;
		logic                rv;
	} lrb_host_s;

	lrb_host_s r_reg;
	lrb_host_s r_next;
	logic [23:0] tbl [0:NCH-1];

	// ==========================================
	// Next state
	always_comb
	begin
		logic        pop;
		logic        push;
		logic [23:0] f;
		logic [7:0]  pv;
		r_next = r_reg;
		push = 1'b0;
		pop = r_reg.rv && rsp_ready;
		f = tbl[r_reg.chan[$clog2(NCH)-1:0]];
		pv = r_reg.cdir ? r_reg.rxb : r_reg.txb;
		r_next.ms = {r_reg.ms[0], link.miso};
		r_next.ir = {r_reg.ir[1:0], link.channel_change_irq};
		if (r_reg.ir[1] && !r_reg.ir[2])
			r_next.hstep = 3'h1;
		if (r_reg.rdy && cmd_valid)
		begin
			// Writes to LRB_A_PRE_H..LRB_A_RXBASE outside sleep and standby are dropped
			if (!(cmd_write && cmd_addr >= `LRB_A_PRE_H && cmd_addr <= `LRB_A_RXBASE &&
				r_reg.mode != lrb_pkg::MODE_SLEEP && r_reg.mode != lrb_pkg::MODE_STBY))
			begin
				r_next.have = 1'b1;
				r_next.cw = cmd_write;
				r_next.ca = cmd_addr;
				r_next.cd = cmd_wdata;
				r_next.cdir = cmd_rx_dir;
			end
		end
		unique case (r_reg.st)
			lrb_pkg::HS_IDLE:
			begin
				r_next.div = 8'h00;
				r_next.bitn = 5'h00;
				r_next.ph = 1'b0;
				if (r_reg.hstep != 3'h0)
				begin
					r_next.kind = r_reg.hstep == 3'h1 ? lrb_pkg::FK_HOPRD : lrb_pkg::FK_HOPWR;
					unique case (r_reg.hstep)
						3'h1:    r_next.sh = {1'b0, `LRB_A_CHAN, 8'h00};
						3'h2:    r_next.sh = {1'b1, `LRB_A_FRF_H, f[23:16]};
						3'h3:    r_next.sh = {1'b1, `LRB_A_FRF_M, f[15:8]};
						default: r_next.sh = {1'b1, `LRB_A_FRF_L, f[7:0]};
					endcase
					r_next.st = lrb_pkg::HS_SHIFT;
				end
				else if (r_reg.have)
				begin
					r_next.st = lrb_pkg::HS_SHIFT;
					if (r_reg.ca == `LRB_A_DATA && (!r_reg.ptr_ok || r_reg.ptr_dir != r_reg.cdir))
					begin
						r_next.kind = lrb_pkg::FK_PTR;
						r_next.sh = {1'b1, `LRB_A_PTR, pv};
					end
					else
					begin
						r_next.kind = lrb_pkg::FK_USER;
						r_next.sh = {r_reg.cw, r_reg.ca, r_reg.cd};
					end
				end
				r_next.cs_n = r_next.st != lrb_pkg::HS_SHIFT;
				r_next.mosi = r_next.sh[15];
			end
			lrb_pkg::HS_SHIFT:
			begin
				r_next.div = r_reg.div + 8'h01;
				if (r_reg.div == 8'(SCK_HALF - 1))
				begin
					r_next.div = 8'h00;
					r_next.ph = ~r_reg.ph;
					r_next.sck = ~r_reg.ph;
					if (r_reg.ph)
					begin
						r_next.rx = {r_reg.rx[6:0], r_reg.ms[1]};
						r_next.bitn = r_reg.bitn + 5'h01;
						r_next.sh = {r_reg.sh[14:0], 1'b0};
						r_next.mosi = r_reg.sh[14];
						if (r_reg.bitn == 5'h0F)
						begin
							r_next.cs_n = 1'b1;
							r_next.st = lrb_pkg::HS_GAP;
						end
					end
				end
			end
			lrb_pkg::HS_GAP:
			begin
				r_next.div = r_reg.div + 8'h01;
				if (r_reg.div == 8'(SCK_HALF - 1))
				begin
					r_next.st = lrb_pkg::HS_IDLE;
					unique case (r_reg.kind)
						lrb_pkg::FK_HOPRD:
						begin
							r_next.chan = r_reg.rx;
							r_next.hstep = 3'h2;
						end
						lrb_pkg::FK_HOPWR:
							r_next.hstep = r_reg.hstep == 3'h4 ? 3'h0 : r_reg.hstep + 3'h1;
						lrb_pkg::FK_PTR:
						begin
							r_next.ptr_ok = 1'b1;
							r_next.ptr_dir = r_reg.cdir;
						end
						lrb_pkg::FK_USER:
						begin
							r_next.have = 1'b0;
							push = !r_reg.cw;
							if (r_reg.cw && r_reg.ca == `LRB_A_OPMODE)
							begin
								r_next.mode = r_reg.cd[2:0];
								r_next.ptr_ok = 1'b0;
							end
							if (r_reg.cw && r_reg.ca == `LRB_A_TXBASE)
								r_next.txb = r_reg.cd;
							if (r_reg.cw && r_reg.ca == `LRB_A_RXBASE)
								r_next.rxb = r_reg.cd;
							if (r_reg.cw && r_reg.ca == `LRB_A_PTR)
								r_next.ptr_ok = 1'b0;
						end
					endcase
				end
			end
			default: r_next.st = lrb_pkg::HS_IDLE;
		endcase
		// Two-entry answer buffer
		if (pop)
			r_next.b0 = r_reg.b1;
		if (push)
		begin
			if (r_reg.cnt == 2'h0 || (r_reg.cnt == 2'h1 && pop))
				r_next.b0 = r_reg.rx;
			else
				r_next.b1 = r_reg.rx;
		end
		r_next.cnt = r_reg.cnt + {1'b0, push} - {1'b0, pop};
		r_next.rv = r_next.cnt != 2'h0;
		r_next.rdy = !r_next.have && r_next.cnt != 2'h2 && r_next.st == lrb_pkg::HS_IDLE;
	end

	// ==========================================
	// Registers and table
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r_reg <= '0;
			r_reg.cs_n <= 1'b1;
			r_reg.st <= lrb_pkg::HS_IDLE;
			r_reg.kind <= lrb_pkg::FK_USER;
		end
		else
			r_reg <= r_next;
	end

	always_ff @(posedge clock)
	begin
		if (tbl_we)
			tbl[tbl_idx[$clog2(NCH)-1:0]] <= tbl_freq;
	end

	assign link.sclk = r_reg.sck;
	assign link.cs_n = r_reg.cs_n;
	assign link.mosi = r_reg.mosi;
	assign cmd_ready = r_reg.rdy;
	assign rsp_valid = r_reg.rv;
	assign rsp_data = r_reg.b0;

endmodule : lrb_host

// ---- lrb_properties.sv ----
`timescale 1ns/1ps
// ==========
// Link checks
module lrb_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic channel_change_irq
);
	logic [4:0] rise_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
			rise_reg <= 5'h00;
		else
			rise_reg <= cs_n ? 5'h00 : rise_reg + {4'h0, $rose(sclk)};
	sclk_idle_a: assert property (cs_n |-> !sclk)
		else $error("sclk out of frame");
	sclk_high_a: assert property ($rose(sclk) |-> sclk[*4])
		else $error("sclk high short");
	sclk_low_a: assert property ($fell(sclk) && !cs_n |-> !sclk[*4])
		else $error("sclk low short");
	frame_gap_a: assert property ($rose(cs_n) |-> cs_n[*4])
		else $error("frame gap short");
	frame_lead_a: assert property ($fell(cs_n) |-> !sclk[*4])
		else $error("frame lead short");
	mosi_hold_a: assert property ($rose(sclk) |=> $stable(mosi)[*3])
		else $error("mosi moved");
	frame_bits_a: assert property ($rose(cs_n) |-> rise_reg == 5'h10)
		else $error("frame not 16 bits");
	irq_hold_a: assert property ($rose(channel_change_irq) |-> channel_change_irq[*8])
		else $error("irq dropped early");
	hop_c: cover property ($rose(channel_change_irq));
	frame_c: cover property ($rose(cs_n));
	miso_c: cover property ($fell(miso));
endmodule : lrb_chk

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "lrb_map.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("wrong value %0t got %0h want %0h", $time, (a), (e)); end end
// ==========
// Bench
module tb_top;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        tbl_we = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, dir = 1'b0, hdr_ok = 1'b1;
	logic        mod_valid, mod_header, cmd_ready, rsp_valid;
	logic [3:0]  dm = 4'h0;
	logic [6:0]  cmd_addr = 7'h00;
	logic [7:0]  cmd_wdata = 8'h00, rsp_data, mod_symbol;
	logic [2:0]  mod_cr, op_mode;
	logic [23:0] carrier_freq;
	logic [11:0] q[$];
	int          error_cnt = 0, checks = 0, nirq = 0, n;
	lrb_if lnk();
	always #50 clock = ~clock;
	always @(negedge clock)
		if (mod_valid === 1'b1)
			q.push_back({mod_header, mod_cr, mod_symbol});
	always @(posedge lnk.channel_change_irq)
		nirq++;
	lrb_dev #(.HOP_LEAD_CYC(50)) i_lrb_dev (.clock(clock), .rst_n(rst_n), .link(lnk), .dm_preamble(dm[3]),
		.dm_header(dm[2]), .dm_header_ok(hdr_ok), .dm_len(8'h01), .dm_cr(3'h2), .dm_crc_on(dm[2]),
		.dm_byte_valid(dm[1]), .dm_byte(8'h77), .dm_end(dm[0]), .mod_valid(mod_valid), .mod_symbol(mod_symbol),
		.mod_cr(mod_cr), .mod_header(mod_header), .rx_cr(), .carrier_freq(carrier_freq), .op_mode(op_mode));
	lrb_host i_lrb_host (.clock(clock), .rst_n(rst_n), .link(lnk), .tbl_we(tbl_we), .tbl_idx(cmd_wdata),
		.tbl_freq({cmd_wdata, 16'h8000}), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_rx_dir(dir), .rsp_valid(rsp_valid), .rsp_ready(1'b1),
		.rsp_data(rsp_data));
	lrb_chk i_lrb_chk (.clock(clock), .rst_n(rst_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi),
		.miso(lnk.miso), .channel_change_irq(lnk.channel_change_irq));
	task automatic summarize();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
		@(negedge clock);
		for (n = 0; n < 60000 && cmd_ready !== 1'b1; n++)
			@(negedge clock);
		{cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, w, a, d};
		@(negedge clock);
		cmd_valid = 1'b0;
		for (n = n; n < 60000 && !w && rsp_valid !== 1'b1; n++)
			@(negedge clock);
		if (!w)
			`CHK(rsp_data, e)
		if (n >= 60000)
		begin
			error_cnt++;
			summarize();
		end
	endtask : xfer
	task automatic t_buf();
		xfer(1'b0, `LRB_A_PRE_L, 8'h00, 8'h0C);
		xfer(1'b1, `LRB_A_OPMODE, 8'h01, 8'h00);
		xfer(1'b1, `LRB_A_TXBASE, 8'hFF, 8'h00);
		xfer(1'b1, `LRB_A_RXBASE, 8'h10, 8'h00);
		for (int i = 0; i < 3; i++)
			xfer(1'b1, `LRB_A_DATA, 8'hA5 + i[7:0], 8'h00);
		xfer(1'b0, `LRB_A_PTR, 8'h00, 8'h02);
		xfer(1'b1, `LRB_A_PTR, 8'h00, 8'h00);
		for (int i = 0; i < 3; i++)
			xfer(1'b0, `LRB_A_DATA, 8'h00, 8'hA5 + i[7:0]);
		$display("buffer test end");
	endtask : t_buf
	task automatic t_rx();
		dir = 1'b1;
		xfer(1'b1, `LRB_A_OPMODE, 8'h05, 8'h00);
		xfer(1'b0, `LRB_A_OPMODE, 8'h00, 8'h05);
		for (int i = 7; i >= 0; i--)
		begin
			hdr_ok = i < 4;
			dm = 4'h1 << (i % 4);
			@(negedge clock);
		end
		dm = 4'h0;
		xfer(1'b0, `LRB_A_RXCNT, 8'h00, 8'h01);
		xfer(1'b0, `LRB_A_RXCR, 8'h00, 8'h0A);
		xfer(1'b0, `LRB_A_FLAGS, 8'h00, 8'h07);
		xfer(1'b1, `LRB_A_OPMODE, 8'h01, 8'h00);
		xfer(1'b0, `LRB_A_DATA, 8'h00, 8'h77);
		$display("receive test end");
	endtask : t_rx
	task automatic t_tx();
		for (int i = 0; i < 16; i++)
		begin
			{tbl_we, cmd_wdata} = {1'b1, i[7:0]};
			@(negedge clock);
		end
		tbl_we = 1'b0;
		dir = 1'b0;
		xfer(1'b1, `LRB_A_MODEM, 8'h72, 8'h00);
		xfer(1'b1, `LRB_A_TXCFG, 8'h81, 8'h00);
		xfer(1'b1, `LRB_A_PAYLEN, 8'h02, 8'h00);
		q.delete();
		xfer(1'b1, `LRB_A_OPMODE, 8'h03, 8'h00);
		for (n = 0; n < 60000 && (q.size() < 17 || op_mode !== 3'h1); n++)
			@(negedge clock);
		if (n >= 60000)
		begin
			error_cnt++;
			summarize();
		end
		`CHK(q.size(), 17)
		`CHK(q[11][11], 1'b0)
		`CHK(q[12], 12'hC02)
		`CHK(q[15], 12'h1A5)
		`CHK(q[16], 12'h1A6)
		`CHK(nirq > 1, 1'b1)
		`CHK(carrier_freq, 24'h018000)
		$display("transmit test end");
	endtask : t_tx
	initial
	begin
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		t_buf();
		t_rx();
		t_tx();
		xfer(1'b1, `LRB_A_OPMODE, 8'h00, 8'h00);
		xfer(1'b0, `LRB_A_DATA, 8'h00, 8'h00);
		xfer(1'b0, `LRB_A_RXCNT, 8'h00, 8'h00);
		$display("sleep test end");
		summarize();
	end
endmodule : tb_top
